//--- logic/chan_div_pkg.sv
/*
 * constants, field layouts and types for the output channel divider block.
 * assumes a 125 MHz system clock and register indices scaled by four on the bus.
 */
package chan_div_pkg;
   // ----------------------------------------------------------------
   // register indices (byte address = index * 4)
   // ----------------------------------------------------------------
   localparam logic [13:0] IDX_CHAN_A_DIV_LOW    = 14'h0428;
   localparam logic [13:0] IDX_CHAN_A_DIV_HIGH   = 14'h0429;
   localparam logic [13:0] IDX_CHAN_A_PHASE      = 14'h042A;
   localparam logic [13:0] IDX_OUTPUT_B_FMT_CFG  = 14'h042B;
   localparam logic [13:0] IDX_CHAN_B_DIV_LOW    = 14'h042C;
   localparam logic [13:0] IDX_CHAN_B_DIV_HIGH   = 14'h042D;
   localparam logic [13:0] IDX_CHAN_B_PHASE      = 14'h042E;
   localparam logic [13:0] IDX_SYNC_MASK_CTRL    = 14'h0430;
   localparam logic [13:0] IDX_CHAN_STATUS       = 14'h0431;

   // ----------------------------------------------------------------
   // widths and field positions
   // ----------------------------------------------------------------
   localparam int DIV_W      = 10;           // channel divide value width
   localparam int CNT_W      = 11;           // half-period counter width
   localparam int PHASE_W    = 6;            // initial phase width
   localparam int DIV_HI_W   = 2;            // upper divide bits in high register
   localparam int FMT_LSB    = 4;            // format field position
   localparam int POL_LSB    = 2;            // polarity field position
   localparam int BOOST_BIT  = 1;            // lvds boost bit
   localparam int CMOS33_BIT = 7;            // 3.3 v cmos driver enable bit

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]         RST_DIV_LOW = 8'h00;
   localparam logic [DIV_HI_W-1:0] RST_DIV_HI = 2'h0;
   localparam logic [PHASE_W-1:0] RST_PHASE   = 6'h00;
   localparam logic [7:0]         RST_FMT_CFG = 8'h10;  // hstl, pos/neg, no boost
   localparam logic [1:0]         RST_MASK    = 2'h0;

   // ----------------------------------------------------------------
   // second output driver formats and polarity codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      FMT_POWER_DOWN = 3'h0,
      FMT_HSTL       = 3'h1,
      FMT_LVDS       = 3'h2,
      FMT_RSVD_3     = 3'h3,
      FMT_CMOS_BOTH  = 3'h4,
      FMT_CMOS_P     = 3'h5,
      FMT_CMOS_N     = 3'h6,
      FMT_RSVD_7     = 3'h7
   } output_fmt_t;

   localparam logic [1:0] POL_POS_NEG = 2'h0;
   localparam logic [1:0] POL_POS_POS = 2'h1;
   localparam logic [1:0] POL_NEG_POS = 2'h2;
   localparam logic [1:0] POL_NEG_NEG = 2'h3;

   // divider states, one-hot
   typedef enum logic [1:0] {
      DIV_STATIC = 2'b01,
      DIV_RUN    = 2'b10
   } div_state_t;
endpackage : chan_div_pkg

//--- logic/chan_div_if.sv
/*
 * carrier between the top block and one channel divider.
 * assumes all signals are on sys_clk.
 */
`timescale 1ns/1ns
interface chan_div_if;
   logic                              half_tick;  // pre-divider clock edge pulse
   logic                              sync_evt;   // sync event pulse
   logic                              sync_mask;  // channel ignores sync
   logic [chan_div_pkg::DIV_W-1:0]    div_val;    // programmed divide value
   logic [chan_div_pkg::PHASE_W-1:0]  phase_val;  // programmed initial phase
   logic                              clk_out;    // divided clock level
   logic                              running;    // divider left static state

   modport ctrl (output half_tick, output sync_evt, output sync_mask, output div_val,
                 output phase_val, input clk_out, input running);
   modport div  (input half_tick, input sync_evt, input sync_mask, input div_val,
                 input phase_val, output clk_out, output running);
endinterface : chan_div_if

//--- logic/channel_divider.sv
/*
 * one 10-bit channel divider with half-period initial phase.
 * assumes half_tick pulses once for every edge of the pre-divider clock, on sys_clk.
 */
`timescale 1ns/1ns
module channel_divider (
   input  wire logic  sys_clk,
   input  wire logic  arst_n,
   chan_div_if.div    dif
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   chan_div_pkg::div_state_t              state_reg,  state_next;  // static or running
   logic [chan_div_pkg::DIV_W-1:0]        div_reg,    div_next;    // loaded divide value
   logic [chan_div_pkg::CNT_W-1:0]        cnt_reg,    cnt_next;    // half-period position
   logic                                  clk_reg,    clk_next;    // divided clock
   logic [chan_div_pkg::CNT_W-1:0]        half_n;                  // half-periods per level
   logic [chan_div_pkg::CNT_W-1:0]        last_pos;                // last position of period
   localparam int CNT_W = chan_div_pkg::CNT_W;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      div_next   = div_reg;
      cnt_next   = cnt_reg;
      if (dif.sync_mask && (state_reg == chan_div_pkg::DIV_STATIC)) begin
         state_next = chan_div_pkg::DIV_RUN;
         div_next   = dif.div_val;
         cnt_next   = CNT_W'(dif.phase_val);
      end else if (dif.sync_evt && !dif.sync_mask) begin
         state_next = chan_div_pkg::DIV_RUN;
         div_next   = dif.div_val;
         cnt_next   = CNT_W'(dif.phase_val);
      end else if ((state_reg == chan_div_pkg::DIV_RUN) && dif.half_tick) begin
         // wrap after two full levels
         cnt_next = (cnt_reg >= last_pos) ? '0 : cnt_reg + CNT_W'(1);
      end
   end

   always_comb begin
      half_n   = CNT_W'(div_reg) + CNT_W'(1);
      last_pos = {half_n[CNT_W-2:0], 1'b0} - CNT_W'(1);
      clk_next = (state_next == chan_div_pkg::DIV_RUN) &&
                 (cnt_next < (CNT_W'(div_next) + CNT_W'(1)));
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= chan_div_pkg::DIV_STATIC;
         div_reg   <= '0;
         cnt_reg   <= '0;
         clk_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         div_reg   <= div_next;
         cnt_reg   <= cnt_next;
         clk_reg   <= clk_next;
      end
   end

   assign dif.clk_out = clk_reg;
   assign dif.running = (state_reg == chan_div_pkg::DIV_RUN);
endmodule : channel_divider

//--- logic/output_channel_divider_cfg.sv
/*
 * output channel pair: two channel dividers, their register file on classic
 * wishbone and the second output driver configuration.
 * assumes pre_div_edge and sync_event come from logic on sys_clk (no synchroniser),
 * pre_div_edge pulsing once per edge of the shared pre-divider clock.
 */
// Register access over Wishbone was left to the implementer.
// Behaviour
// - divide by ten-bit value plus one
// - low byte plus two high bits
// - initial phase in half input periods
// - format field selects second output mode
// - polarity applies only in cmos mode
// - enable bit selects 3.3 v cmos driver
// - boost bit selects lvds drive strength
// - masked channel runs freely, ignores sync
`timescale 1ns/1ns
module output_channel_divider_cfg (
   input  wire logic         sys_clk,
   input  wire logic         arst_n,
   // classic wishbone slave
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [15:0]  wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   // divider input clock edge and sync event
   input  wire logic         pre_div_edge,
   input  wire logic         sync_event,
   // divided channel clocks
   output logic              chan_a_clk,
   output logic              chan_b_clk,
   // second output driver controls
   output logic              out_b_power_down,
   output logic              out_b_hstl_en,
   output logic              out_b_lvds_en,
   output logic              out_b_cmos_en,
   output logic              out_b_cmos33_en,
   output logic              out_b_lvds_boost,
   output logic              out_b_p_en,
   output logic              out_b_n_en,
   output logic              out_b_p_level,
   output logic              out_b_n_level
);
   localparam int DIV_W   = chan_div_pkg::DIV_W;
   localparam int PHASE_W = chan_div_pkg::PHASE_W;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // bus address matches a register index
   function automatic logic reg_hit(input logic [15:0] adr, input logic [13:0] idx);
      reg_hit = (adr[15:2] == idx);
   endfunction : reg_hit

   // cmos format codes
   function automatic logic is_cmos(input logic [2:0] fmt);
      is_cmos = (fmt == chan_div_pkg::FMT_CMOS_BOTH) || (fmt == chan_div_pkg::FMT_CMOS_P) ||
                (fmt == chan_div_pkg::FMT_CMOS_N);
   endfunction : is_cmos

   // ----------------------------------------------------------------
   // register file state
   // ----------------------------------------------------------------
   logic [7:0]           a_lo_reg,   a_lo_next;    // chan_a_div_low
   logic [1:0]           a_hi_reg,   a_hi_next;    // chan_a_div_high
   logic [PHASE_W-1:0]   a_ph_reg,   a_ph_next;    // chan_a_phase
   logic [7:0]           fmt_reg,    fmt_next;     // output_b_format_cfg
   logic [7:0]           b_lo_reg,   b_lo_next;    // chan_b_div_low
   logic [1:0]           b_hi_reg,   b_hi_next;    // chan_b_div_high
   logic [PHASE_W-1:0]   b_ph_reg,   b_ph_next;    // chan_b_phase
   logic [1:0]           mask_reg,   mask_next;    // sync masks, bit0 a, bit1 b
   logic                 ack_reg,    ack_next;     // wishbone acknowledge
   logic [31:0]          rdat_reg,   rdat_next;    // wishbone read data
   logic                 wr_lane0;                 // write commits this cycle
   logic [7:0]           wbyte;                    // written byte

   // divider carriers
   chan_div_if  a_if ();
   chan_div_if  b_if ();

   // ----------------------------------------------------------------
   // wishbone access
   // ----------------------------------------------------------------
   // answer one cycle after the request, drop the cycle after
   always_comb begin
      ack_next  = wb_cyc_i && wb_stb_i && !ack_reg;
      rdat_next = rdat_reg;
      if (wb_cyc_i && wb_stb_i && !ack_reg) begin
         // unmapped and reserved bits read zero
         rdat_next = '0;
         if (reg_hit(wb_adr_i, chan_div_pkg::IDX_CHAN_A_DIV_LOW)) begin
            rdat_next[7:0] = a_lo_reg;
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_CHAN_A_DIV_HIGH)) begin
            rdat_next[1:0] = a_hi_reg;
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_CHAN_A_PHASE)) begin
            rdat_next[PHASE_W-1:0] = a_ph_reg;
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_OUTPUT_B_FMT_CFG)) begin
            rdat_next[7:0] = fmt_reg;
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_CHAN_B_DIV_LOW)) begin
            rdat_next[7:0] = b_lo_reg;
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_CHAN_B_DIV_HIGH)) begin
            rdat_next[1:0] = b_hi_reg;
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_CHAN_B_PHASE)) begin
            rdat_next[PHASE_W-1:0] = b_ph_reg;
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_SYNC_MASK_CTRL)) begin
            rdat_next[1:0] = mask_reg;
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_CHAN_STATUS)) begin
            // running flags and live channel clocks
            rdat_next[3:0] = {b_if.clk_out, a_if.clk_out, b_if.running, a_if.running};
         end
      end
   end

   // writes commit on the edge that sees ack high
   assign wr_lane0 = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
   assign wbyte    = wb_dat_i[7:0];

   // register write decode, reserved bits dropped
   always_comb begin
      a_lo_next = a_lo_reg;
      a_hi_next = a_hi_reg;
      a_ph_next = a_ph_reg;
      fmt_next  = fmt_reg;
      b_lo_next = b_lo_reg;
      b_hi_next = b_hi_reg;
      b_ph_next = b_ph_reg;
      mask_next = mask_reg;
      if (wr_lane0) begin
         if (reg_hit(wb_adr_i, chan_div_pkg::IDX_CHAN_A_DIV_LOW)) begin
            a_lo_next = wbyte;
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_CHAN_A_DIV_HIGH)) begin
            a_hi_next = wbyte[1:0];
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_CHAN_A_PHASE)) begin
            a_ph_next = wbyte[PHASE_W-1:0];
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_OUTPUT_B_FMT_CFG)) begin
            // bit 0 reserved, reads zero
            fmt_next = {wbyte[7:1], 1'b0};
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_CHAN_B_DIV_LOW)) begin
            b_lo_next = wbyte;
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_CHAN_B_DIV_HIGH)) begin
            b_hi_next = wbyte[1:0];
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_CHAN_B_PHASE)) begin
            b_ph_next = wbyte[PHASE_W-1:0];
         end else if (reg_hit(wb_adr_i, chan_div_pkg::IDX_SYNC_MASK_CTRL)) begin
            mask_next = wbyte[1:0];
         end
      end
   end

   // register bank
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         a_lo_reg <= chan_div_pkg::RST_DIV_LOW;
         a_hi_reg <= chan_div_pkg::RST_DIV_HI;
         a_ph_reg <= chan_div_pkg::RST_PHASE;
         fmt_reg  <= chan_div_pkg::RST_FMT_CFG;
         b_lo_reg <= chan_div_pkg::RST_DIV_LOW;
         b_hi_reg <= chan_div_pkg::RST_DIV_HI;
         b_ph_reg <= chan_div_pkg::RST_PHASE;
         mask_reg <= chan_div_pkg::RST_MASK;
         ack_reg  <= 1'b0;
         rdat_reg <= '0;
      end else begin
         a_lo_reg <= a_lo_next;
         a_hi_reg <= a_hi_next;
         a_ph_reg <= a_ph_next;
         fmt_reg  <= fmt_next;
         b_lo_reg <= b_lo_next;
         b_hi_reg <= b_hi_next;
         b_ph_reg <= b_ph_next;
         mask_reg <= mask_next;
         ack_reg  <= ack_next;
         rdat_reg <= rdat_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

   // ----------------------------------------------------------------
   // channel dividers
   // ----------------------------------------------------------------
   // assemble ten-bit value
   assign a_if.div_val   = {a_hi_reg, a_lo_reg};
   assign b_if.div_val   = {b_hi_reg, b_lo_reg};
   assign a_if.phase_val = a_ph_reg;
   assign b_if.phase_val = b_ph_reg;
   assign a_if.half_tick = pre_div_edge;
   assign b_if.half_tick = pre_div_edge;
   assign a_if.sync_evt  = sync_event;
   assign b_if.sync_evt  = sync_event;
   assign a_if.sync_mask = mask_reg[0];
   assign b_if.sync_mask = mask_reg[1];

   channel_divider u_first_channel_divider (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .dif     (a_if)
   );

   channel_divider u_second_channel_divider (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .dif     (b_if)
   );

   // ----------------------------------------------------------------
   // second output driver decode
   // ----------------------------------------------------------------
   logic [2:0]  fmt_code;                       // format field
   logic [1:0]  pol_code;                       // polarity field
   logic        pd_next, hstl_next, lvds_next;  // mode flags
   logic        cmos_next, c33_next, boost_next;
   logic        p_en_next, n_en_next;           // output leg enables
   logic        p_lvl_next, n_lvl_next;         // leg levels
   logic        a_clk_reg, b_clk_reg;           // channel clock outputs
   logic        pd_reg, hstl_reg, lvds_reg, cmos_reg, c33_reg, boost_reg;
   logic        p_en_reg, n_en_reg, p_lvl_reg, n_lvl_reg;

   assign fmt_code = fmt_reg[chan_div_pkg::FMT_LSB +: 3];
   assign pol_code = fmt_reg[chan_div_pkg::POL_LSB +: 2];

   always_comb begin
      pd_next    = 1'b0;
      hstl_next  = 1'b0;
      lvds_next  = 1'b0;
      cmos_next  = 1'b0;
      p_en_next  = 1'b0;
      n_en_next  = 1'b0;
      unique case (fmt_code)
         chan_div_pkg::FMT_HSTL: begin
            hstl_next = 1'b1;
            p_en_next = 1'b1;
            n_en_next = 1'b1;
         end
         chan_div_pkg::FMT_LVDS: begin
            lvds_next = 1'b1;
            p_en_next = 1'b1;
            n_en_next = 1'b1;
         end
         chan_div_pkg::FMT_CMOS_BOTH: begin
            cmos_next = 1'b1;
            p_en_next = 1'b1;
            n_en_next = 1'b1;
         end
         chan_div_pkg::FMT_CMOS_P: begin
            cmos_next = 1'b1;
            p_en_next = 1'b1;
         end
         chan_div_pkg::FMT_CMOS_N: begin
            cmos_next = 1'b1;
            n_en_next = 1'b1;
         end
         // power-down and reserved codes tristate the pair
         default: begin
            pd_next = 1'b1;
         end
      endcase
      c33_next   = fmt_reg[chan_div_pkg::CMOS33_BIT];
      boost_next = fmt_reg[chan_div_pkg::BOOST_BIT] && lvds_next;
      if (is_cmos(fmt_code)) begin
         p_lvl_next = b_if.clk_out ^ pol_code[1];
         n_lvl_next = b_if.clk_out ~^ ^pol_code;
      end else begin
         p_lvl_next = b_if.clk_out;
         n_lvl_next = ~b_if.clk_out;
      end
      // disabled legs held low
      p_lvl_next = p_lvl_next && p_en_next;
      n_lvl_next = n_lvl_next && n_en_next;
   end

   // output registers
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         a_clk_reg <= 1'b0;
         b_clk_reg <= 1'b0;
         pd_reg    <= 1'b0;
         hstl_reg  <= 1'b0;
         lvds_reg  <= 1'b0;
         cmos_reg  <= 1'b0;
         c33_reg   <= 1'b0;
         boost_reg <= 1'b0;
         p_en_reg  <= 1'b0;
         n_en_reg  <= 1'b0;
         p_lvl_reg <= 1'b0;
         n_lvl_reg <= 1'b0;
      end else begin
         a_clk_reg <= a_if.clk_out;
         b_clk_reg <= b_if.clk_out;
         pd_reg    <= pd_next;
         hstl_reg  <= hstl_next;
         lvds_reg  <= lvds_next;
         cmos_reg  <= cmos_next;
         c33_reg   <= c33_next;
         boost_reg <= boost_next;
         p_en_reg  <= p_en_next;
         n_en_reg  <= n_en_next;
         p_lvl_reg <= p_lvl_next;
         n_lvl_reg <= n_lvl_next;
      end
   end

   assign chan_a_clk       = a_clk_reg;
   assign chan_b_clk       = b_clk_reg;
   assign out_b_power_down = pd_reg;
   assign out_b_hstl_en    = hstl_reg;
   assign out_b_lvds_en    = lvds_reg;
   assign out_b_cmos_en    = cmos_reg;
   assign out_b_cmos33_en  = c33_reg;
   assign out_b_lvds_boost = boost_reg;
   assign out_b_p_en       = p_en_reg;
   assign out_b_n_en       = n_en_reg;
   assign out_b_p_level    = p_lvl_reg;
   assign out_b_n_level    = n_lvl_reg;
endmodule : output_channel_divider_cfg

//--- verif/output_channel_divider_cfg_monitor.sv
/* port checker for output_channel_divider_cfg.
   assumes one clock domain and an asynchronous active-low reset. */
`timescale 1ns/1ns
module output_channel_divider_cfg_monitor (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic pre_div_edge,
   input wire logic sync_event,
   input wire logic chan_a_clk,
   input wire logic chan_b_clk,
   input wire logic out_b_power_down,
   input wire logic out_b_hstl_en,
   input wire logic out_b_lvds_en,
   input wire logic out_b_cmos_en,
   input wire logic out_b_cmos33_en,
   input wire logic out_b_lvds_boost,
   input wire logic out_b_p_en,
   input wire logic out_b_n_en,
   input wire logic out_b_p_level,
   input wire logic out_b_n_level
);
   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_next: assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o)
      else $error("ack not one cycle after request");
   // a clock level only moves after an edge, a sync or a bus write
   a_clk_a_cause: assert property ($changed(chan_a_clk) |-> $past(pre_div_edge, 2) || $past(sync_event, 2)
      || $past(wb_ack_o, 2) || $past(wb_ack_o, 3) || $past(wb_ack_o, 4)) else $error("first clock moved alone");
   a_clk_b_cause: assert property ($changed(chan_b_clk) |-> $past(pre_div_edge, 2) || $past(sync_event, 2)
      || $past(wb_ack_o, 2) || $past(wb_ack_o, 3) || $past(wb_ack_o, 4)) else $error("second clock moved alone");
   a_cmos33_write: assert property ($changed(out_b_cmos33_en) |-> $past(wb_ack_o, 1) || $past(wb_ack_o, 2)
      || $past(wb_ack_o, 3)) else $error("driver enable moved without write");
   a_mode_onehot: assert property ($onehot0({out_b_power_down, out_b_hstl_en, out_b_lvds_en, out_b_cmos_en}))
      else $error("output modes not exclusive");
   a_boost_lvds: assert property (out_b_lvds_boost |-> out_b_lvds_en)
      else $error("boost outside lvds");
   a_leg_off_low: assert property (!(!out_b_p_en && out_b_p_level) && !(!out_b_n_en && out_b_n_level))
      else $error("disabled leg driven high");
   a_pol_differential: assert property (!out_b_cmos_en && out_b_p_en |-> out_b_p_level != out_b_n_level)
      else $error("polarity applied outside cmos");
   // main scenarios reached
   c_sync_start: cover property (sync_event ##2 chan_a_clk);
   c_boost: cover property (out_b_lvds_boost);
   c_cmos_level: cover property (out_b_cmos_en && out_b_p_level);
endmodule : output_channel_divider_cfg_monitor

//--- verif/output_channel_divider_cfg_tb.sv
/* self-checking bench for output_channel_divider_cfg.
   assumes the package and design files are compiled before it. */
`timescale 1ns/1ns
module output_channel_divider_cfg_tb;
   // -------------------------------------------------------------
   // signals and model state
   // -------------------------------------------------------------
   logic        sys_clk, arst_n, cyc, stb, we, pde, sev, b, cm, pe, ne;
   logic [15:0] adr;
   logic [31:0] dati, rd, seed, v;
   logic [13:0] x;
   logic [2:0]  f;
   logic [1:0]  pl;
   logic [9:0]  e;
   wire  [31:0] dato;
   wire  [9:0]  o;                  // second output controls, power-down first
   wire         ack, ca, cb;
   int          n_mismatch, cmp_count, n[2], p[2], nd[2], ph[2], msk[2];
   output_channel_divider_cfg dut (.sys_clk, .arst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack),
      .pre_div_edge(pde), .sync_event(sev), .chan_a_clk(ca), .chan_b_clk(cb),
      .out_b_power_down(o[9]), .out_b_hstl_en(o[8]), .out_b_lvds_en(o[7]), .out_b_cmos_en(o[6]),
      .out_b_cmos33_en(o[5]), .out_b_lvds_boost(o[4]), .out_b_p_en(o[3]), .out_b_n_en(o[2]),
      .out_b_p_level(o[1]), .out_b_n_level(o[0]));
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // one classic cycle, held until ack is sampled high
   task automatic bus(input logic w, input logic [13:0] i, input logic [7:0] d);
      int t;
      @(posedge sys_clk);
      {cyc, stb, we, adr, dati} <= {2'b11, w, i, 2'b00, 24'h0, d};
      t = 0;
      do begin
         @(posedge sys_clk);
         t++;
      end while (ack !== 1'b1 && t < 50);
      rd = dato;
      {cyc, stb} <= 2'b00;
      if (t >= 50) n_mismatch++;
   endtask : bus
   // divide value and phase of one channel, loaded at the next sync
   task automatic setdiv(input int c, input int d, input int q);
      x = chan_div_pkg::IDX_CHAN_A_DIV_LOW + 14'(4 * c);
      bus(1, x, 8'(d));
      bus(1, x + 14'h1, 8'(d >> 8));
      bus(1, x + 14'h2, 8'(q));
      nd[c] = d + 1;
      ph[c] = q;
   endtask : setdiv
   // one pre-divider edge or one sync, then both clocks against the model
   task automatic step(input logic s);
      @(posedge sys_clk);
      {pde, sev} <= {!s, s};
      @(posedge sys_clk);
      {pde, sev} <= 2'b00;
      @(posedge sys_clk);
      @(negedge sys_clk);
      for (int c = 0; c < 2; c++) begin
         if (s && msk[c] == 0) {n[c], p[c]} = {nd[c], ph[c]};
         else if (!s) p[c] = p[c] >= 2 * n[c] - 1 ? 0 : p[c] + 1;
      end
      chk("chan_a_clk", 32'(ca), 32'(p[0] < n[0]));
      chk("chan_b_clk", 32'(cb), 32'(p[1] < n[1]));
   endtask : step
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   // -------------------------------------------------------------
   // clock, watchdog and sequence
   // -------------------------------------------------------------
   initial begin
      sys_clk = 0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (40000) @(posedge sys_clk);
      n_mismatch++;
      test_done();
   end
   initial begin
      {arst_n, cyc, stb, we, pde, sev, adr, dati} = '0;
      {n_mismatch, cmp_count, msk[0], msk[1]} = '0;
      seed = 32'hECB3EF85;
      repeat (12) @(posedge sys_clk);
      arst_n <= 1;
      // reset values and read-back through field masks, 0x42F unmapped
      for (int i = 0; i < 8; i++) begin
         x = 14'h0428 + 14'(i);
         bus(0, x, 0);
         chk("reset", rd, x == 14'h042B ? 32'(chan_div_pkg::RST_FMT_CFG) : 0);
         v = rnd() & 32'hFE;
         bus(1, x, v[7:0]);
         bus(0, x, 0);
         chk("readback", rd, v & (x[1:0] == 1 ? 3 : x[1:0] == 2 ? 32'h3F : x == 14'h042F ? 0 : 32'hFF));
      end
      // every format, polarity and boost, dividers static
      for (int k = 0; k < 64; k++) begin
         {f, pl, b} = 6'(k);
         cm = f[2] && f != 3'h7;
         bus(1, chan_div_pkg::IDX_OUTPUT_B_FMT_CFG, {cm & f[0], f, pl, b, 1'b0});
         repeat (3) @(posedge sys_clk);
         @(negedge sys_clk);
         pe = f == 3'h1 || f == 3'h2 || f == 3'h4 || f == 3'h5;
         ne = f == 3'h1 || f == 3'h2 || f == 3'h4 || f == 3'h6;
         e = {f == 3'h0 || f == 3'h3 || f == 3'h7, f == 3'h1, f == 3'h2, cm, cm & f[0], b && f == 3'h2, pe, ne,
              pe && cm && pl[1], ne && !(cm && ^pl)};
         chk("out_b", 32'(o), 32'(e));
      end
      // boundary and random divide values and phases
      for (int t = 0; t < 3; t++) begin
         setdiv(0, t == 0 ? 0 : t == 1 ? 1023 : rnd() % 40, rnd() % 64);
         setdiv(1, rnd() % 40, rnd() % 64);
         step(1);
         repeat (2 * (nd[0] > nd[1] ? nd[0] : nd[1]) + 70) step(0);
      end
      // new value waits for sync; masked channel ignores sync
      setdiv(0, 7, 0);
      repeat (30) step(0);
      bus(1, chan_div_pkg::IDX_SYNC_MASK_CTRL, 8'h01);
      msk[0] = 1;
      setdiv(1, 3, 1);
      step(1);
      repeat (30) step(0);
      bus(1, chan_div_pkg::IDX_SYNC_MASK_CTRL, 8'h00);
      msk[0] = 0;
      step(1);
      repeat (20) step(0);
      // mask frees static divider
      @(posedge sys_clk) arst_n <= 0;
      @(posedge sys_clk) arst_n <= 1;
      n = '{1, 0};
      p[0] = 0;
      bus(1, chan_div_pkg::IDX_SYNC_MASK_CTRL, 1);
      repeat (8) step(0);
      test_done();
   end
endmodule : output_channel_divider_cfg_tb
bind output_channel_divider_cfg output_channel_divider_cfg_monitor mon (.sys_clk, .arst_n, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .pre_div_edge, .sync_event, .chan_a_clk, .chan_b_clk, .out_b_power_down,
   .out_b_hstl_en, .out_b_lvds_en, .out_b_cmos_en, .out_b_cmos33_en, .out_b_lvds_boost, .out_b_p_en,
   .out_b_n_en, .out_b_p_level, .out_b_n_level);
